// file: hw/ffo_offset.sv
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "ffo_defines.svh"

module ffo_offset
   import ffo_pkg::*;
#(
   parameter int DATA_W = `FFO_DATA_W,
   parameter int DEPTH  = `FFO_DEPTH,
   parameter int OFS_W  = `FFO_OFS_W
)
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic              master_reset_n_i,
   input  wire logic              partial_reset_n_i,
   input  wire logic              fall_through_mode_i,
   input  wire ffo_ctl_t          ctl_i,
   input  wire logic              write_clock_i,
   input  wire logic              read_clock_i,
   input  wire logic [DATA_W-1:0] data_in_i,
   input  wire logic              serial_offset_in_i,
   output logic [DATA_W-1:0]      data_out_o,
   output logic                   almost_empty_flag_o,
   output logic                   almost_full_flag_o,
   output logic                   input_ready_flag_o,
   output logic                   almost_empty_valid_o,
   output logic                   almost_full_valid_o,
   input  wire logic [3:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 2);
   localparam int SW = 2 * OFS_W;
   localparam int BW = $clog2(SW);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic ffo_wop_t wr_decode(input ffo_ctl_t c);
      wr_decode = WOP_NONE;
      if (c.load_sel && !c.wr_strobe_n)
         wr_decode = WOP_MEM;
      else if (!c.load_sel && !c.wr_strobe_n && c.rd_strobe_n && c.sen_n)
         wr_decode = WOP_PAR;
      else if (!c.load_sel && c.wr_strobe_n && c.rd_strobe_n && !c.sen_n)
         wr_decode = WOP_SER;
   endfunction

   function automatic ffo_rop_t rd_decode(input ffo_ctl_t c);
      rd_decode = ROP_NONE;
      if (c.load_sel && !c.rd_strobe_n)
         rd_decode = ROP_MEM;
      else if (!c.load_sel && c.wr_strobe_n && !c.rd_strobe_n && c.sen_n)
         rd_decode = ROP_OFS;
   endfunction

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem_reg [DEPTH];
   logic [PW-1:0]     wptr_reg, wptr_next;
   logic [PW-1:0]     rptr_reg, rptr_next;
   logic [CW-1:0]     mcnt_reg, mcnt_next;
   logic              out_full_reg, out_full_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic [OFS_W-1:0]  ofs_empty_reg, ofs_empty_next;
   logic [OFS_W-1:0]  ofs_full_reg, ofs_full_next;
   logic [SW-1:0]     shadow_reg, shadow_next;
   logic [BW-1:0]     bitpos_reg, bitpos_next;
   logic              wofs_ptr_reg, wofs_ptr_next;
   logic              rofs_ptr_reg, rofs_ptr_next;
   ffo_method_t       method_reg, method_next;
   logic              fall_through_mode_reg, fall_through_mode_next;
   logic [1:0]        pae_wait_reg, pae_wait_next;
   logic [1:0]        paf_wait_reg, paf_wait_next;
   logic              pae_ok_reg, pae_ok_next;
   logic              paf_ok_reg, paf_ok_next;
   logic              gate_reg, gate_next;
   logic              ack_reg, ack_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic              mem_we;
   ffo_wop_t          wop;
   ffo_rop_t          rop;
   logic              inc, dec;
   logic [CW-1:0]     total;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      wptr_next      = wptr_reg;
      rptr_next      = rptr_reg;
      mcnt_next      = mcnt_reg;
      out_full_next  = out_full_reg;
      dout_next      = dout_reg;
      ofs_empty_next = ofs_empty_reg;
      ofs_full_next  = ofs_full_reg;
      shadow_next    = shadow_reg;
      bitpos_next    = bitpos_reg;
      wofs_ptr_next  = wofs_ptr_reg;
      rofs_ptr_next  = rofs_ptr_reg;
      method_next    = method_reg;
      fall_through_mode_next      = fall_through_mode_reg;
      pae_wait_next  = pae_wait_reg;
      paf_wait_next  = paf_wait_reg;
      pae_ok_next    = pae_ok_reg;
      paf_ok_next    = paf_ok_reg;
      mem_we         = 1'b0;
      inc            = 1'b0;
      dec            = 1'b0;
      wop = (write_clock_i && gate_reg) ? wr_decode(ctl_i) : WOP_NONE;
      rop = (read_clock_i && gate_reg) ? rd_decode(ctl_i) : ROP_NONE;
      if (!master_reset_n_i)
      begin
         method_next    = ctl_i.load_sel ? METH_SER : METH_PAR;
         fall_through_mode_next      = fall_through_mode_i;
         ofs_empty_next = ctl_i.load_sel ? OFS_W'(`FFO_DEF_SER) : OFS_W'(`FFO_DEF_PAR);
         ofs_full_next  = ctl_i.load_sel ? OFS_W'(`FFO_DEF_SER) : OFS_W'(`FFO_DEF_PAR);
         wofs_ptr_next  = 1'b0;
         rofs_ptr_next  = 1'b0;
         bitpos_next    = '0;
         wptr_next      = '0;
         rptr_next      = '0;
         mcnt_next      = '0;
         out_full_next  = 1'b0;
         dout_next      = '0;
         pae_ok_next    = 1'b1;
         paf_ok_next    = 1'b1;
         pae_wait_next  = '0;
         paf_wait_next  = '0;
      end
      else if (!partial_reset_n_i)
      begin
         wptr_next     = '0;
         rptr_next     = '0;
         mcnt_next     = '0;
         out_full_next = 1'b0;
         dout_next     = '0;
      end
      else
      begin
         if (write_clock_i && paf_wait_reg != 2'h0)
         begin
            paf_wait_next = paf_wait_reg - 2'h1;
            if (paf_wait_reg == 2'h1)
               paf_ok_next = 1'b1;
         end
         if (read_clock_i && pae_wait_reg != 2'h0)
         begin
            pae_wait_next = pae_wait_reg - 2'h1;
            if (pae_wait_reg == 2'h1)
               pae_ok_next = 1'b1;
         end
         unique case (wop)
            WOP_NONE: ;
            WOP_PAR:
               if (method_reg == METH_PAR)
               begin
                  if (!wofs_ptr_reg)
                  begin
                     ofs_empty_next = data_in_i[OFS_W-1:0];
                     pae_ok_next    = 1'b0;
                     paf_ok_next    = 1'b0;
                     paf_wait_next  = '0;
                     pae_wait_next  = `FFO_VALID_DLY;
                  end
                  else
                  begin
                     ofs_full_next = data_in_i[OFS_W-1:0];
                     paf_ok_next   = 1'b0;
                     paf_wait_next = `FFO_VALID_DLY;
                  end
                  wofs_ptr_next = ~wofs_ptr_reg;
               end
            WOP_SER:
               if (method_reg == METH_SER)
               begin
                  shadow_next[bitpos_reg] = serial_offset_in_i;
                  if (bitpos_reg == '0)
                  begin
                     pae_ok_next   = 1'b0;
                     paf_ok_next   = 1'b0;
                     pae_wait_next = '0;
                     paf_wait_next = '0;
                  end
                  if (bitpos_reg == BW'(SW - 1))
                  begin
                     ofs_empty_next = shadow_next[OFS_W-1:0];
                     ofs_full_next  = shadow_next[SW-1:OFS_W];
                     bitpos_next    = '0;
                     pae_wait_next  = `FFO_VALID_DLY;
                     paf_wait_next  = `FFO_VALID_DLY;
                  end
                  else
                     bitpos_next = bitpos_reg + BW'(1);
               end
            WOP_MEM:
               if (mcnt_reg != CW'(DEPTH))
               begin
                  mem_we    = 1'b1;
                  wptr_next = ptr_inc(wptr_reg);
                  inc       = 1'b1;
               end
         endcase
         unique case (rop)
            ROP_NONE:
               if (read_clock_i && fall_through_mode_reg && !out_full_reg && mcnt_reg != '0)
               begin
                  dout_next     = mem_reg[rptr_reg];
                  rptr_next     = ptr_inc(rptr_reg);
                  out_full_next = 1'b1;
                  dec           = 1'b1;
               end
            ROP_OFS:
            begin
               dout_next     = DATA_W'(rofs_ptr_reg ? ofs_full_reg : ofs_empty_reg);
               out_full_next = 1'b0;
               rofs_ptr_next = ~rofs_ptr_reg;
            end
            ROP_MEM:
               if (mcnt_reg != '0)
               begin
                  dout_next     = mem_reg[rptr_reg];
                  rptr_next     = ptr_inc(rptr_reg);
                  out_full_next = fall_through_mode_reg;
                  dec           = 1'b1;
               end
               else
                  out_full_next = 1'b0;
         endcase
         mcnt_next = mcnt_reg + CW'(inc) - CW'(dec);
      end
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   always_comb
   begin
      total = mcnt_reg + CW'(fall_through_mode_reg && out_full_reg);
      if (fall_through_mode_reg)
      begin
         almost_empty_flag_o = total >= CW'(ofs_empty_reg) + CW'(2);
         almost_full_flag_o  = total < CW'(DEPTH + 1) - CW'(ofs_full_reg);
         input_ready_flag_o  = total == CW'(DEPTH + 1);
      end
      else
      begin
         almost_empty_flag_o = total > CW'(ofs_empty_reg);
         almost_full_flag_o  = total < CW'(DEPTH) - CW'(ofs_full_reg);
         input_ready_flag_o  = total == CW'(DEPTH);
      end
   end

   // ----------------------------------------------------------------
   // avalon slave
   // ----------------------------------------------------------------
   always_comb
   begin
      ack_next   = (avs_read_i || avs_write_i) && !ack_reg;
      gate_next  = gate_reg;
      rdata_next = rdata_reg;
      if (avs_read_i && !ack_reg)
      begin
         unique case (avs_address_i)
            `FFO_REG_STATUS: rdata_next = {27'h0000000, input_ready_flag_o, fall_through_mode_reg, method_reg == METH_SER,
                                           pae_ok_reg, paf_ok_reg};
            `FFO_REG_OFFSET: rdata_next = {16'(ofs_full_reg), 16'(ofs_empty_reg)};
            `FFO_REG_CTRL:   rdata_next = {31'h0, gate_reg};
            `FFO_REG_SERPOS: rdata_next = 32'(bitpos_reg);
            default:         rdata_next = 32'h0;
         endcase
      end
      if (avs_write_i && ack_reg && avs_address_i == `FFO_REG_CTRL && avs_byteenable_i[0])
         gate_next = avs_writedata_i[0];
   end

   assign avs_waitrequest_o    = (avs_read_i || avs_write_i) && !ack_reg;
   assign avs_readdata_o       = rdata_reg;
   assign data_out_o           = dout_reg;
   assign almost_empty_valid_o = pae_ok_reg;
   assign almost_full_valid_o  = paf_ok_reg;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      if (mem_we)
         mem_reg[wptr_reg] <= data_in_i;
   end

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         wptr_reg      <= '0;
         rptr_reg      <= '0;
         mcnt_reg      <= '0;
         out_full_reg  <= 1'b0;
         dout_reg      <= '0;
         ofs_empty_reg <= OFS_W'(`FFO_DEF_PAR);
         ofs_full_reg  <= OFS_W'(`FFO_DEF_PAR);
         shadow_reg    <= '0;
         bitpos_reg    <= '0;
         wofs_ptr_reg  <= 1'b0;
         rofs_ptr_reg  <= 1'b0;
         method_reg    <= METH_PAR;
         fall_through_mode_reg      <= 1'b0;
         pae_wait_reg  <= '0;
         paf_wait_reg  <= '0;
         pae_ok_reg    <= 1'b1;
         paf_ok_reg    <= 1'b1;
         gate_reg      <= `FFO_CTRL_RST;
         ack_reg       <= 1'b0;
         rdata_reg     <= '0;
      end
      else
      begin
         wptr_reg      <= wptr_next;
         rptr_reg      <= rptr_next;
         mcnt_reg      <= mcnt_next;
         out_full_reg  <= out_full_next;
         dout_reg      <= dout_next;
         ofs_empty_reg <= ofs_empty_next;
         ofs_full_reg  <= ofs_full_next;
         shadow_reg    <= shadow_next;
         bitpos_reg    <= bitpos_next;
         wofs_ptr_reg  <= wofs_ptr_next;
         rofs_ptr_reg  <= rofs_ptr_next;
         method_reg    <= method_next;
         fall_through_mode_reg      <= fall_through_mode_next;
         pae_wait_reg  <= pae_wait_next;
         paf_wait_reg  <= paf_wait_next;
         pae_ok_reg    <= pae_ok_next;
         paf_ok_reg    <= paf_ok_next;
         gate_reg      <= gate_next;
         ack_reg       <= ack_next;
         rdata_reg     <= rdata_next;
      end
   end

endmodule

// file: inc/ffo_defines.svh
`ifndef FFO_DEFINES_SVH
`define FFO_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define FFO_DATA_W      18
`define FFO_DEPTH       8192
`define FFO_OFS_W       13

// ----------------------------------------------------------------
// offset defaults after master reset
// ----------------------------------------------------------------
`define FFO_DEF_PAR     14'h007f
`define FFO_DEF_SER     14'h03ff

// ----------------------------------------------------------------
// flag validity delay in link edges
// ----------------------------------------------------------------
`define FFO_VALID_DLY   2'h2

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define FFO_REG_STATUS  4'h0
`define FFO_REG_OFFSET  4'h4
`define FFO_REG_CTRL    4'h8
`define FFO_REG_SERPOS  4'hc
`define FFO_CTRL_RST    1'h1

`endif

// file: inc/ffo_pkg.sv
package ffo_pkg;

   typedef struct packed {
      logic load_sel;
      logic wr_strobe_n;
      logic rd_strobe_n;
      logic sen_n;
   } ffo_ctl_t;

   typedef enum logic {METH_PAR, METH_SER} ffo_method_t;

   typedef enum logic [1:0] {WOP_NONE, WOP_PAR, WOP_SER, WOP_MEM} ffo_wop_t;

   typedef enum logic [1:0] {ROP_NONE, ROP_OFS, ROP_MEM} ffo_rop_t;

endpackage

// file: bench/ffo_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller on the write and read ports
// ----------------------------------------
module ffo_ctrl_model
   import ffo_pkg::*;
(
   input  wire logic        clock_i,
   output ffo_ctl_t         ctl_o,
   output logic             write_clock_o,
   output logic             read_clock_o,
   output logic [17:0]      data_o,
   output logic             serial_o
);
   initial
   begin
      ctl_o = 4'b1111;
      write_clock_o = 1'b0;
      read_clock_o = 1'b0;
      data_o = 18'h00000;
      serial_o = 1'b0;
   end
   task automatic hold(input ffo_ctl_t c);
      @(posedge clock_i);
      ctl_o <= c;
   endtask
   // one edge of each requested clock (read dropped if both are asked with load_sel low), then release
   task automatic drive(input ffo_ctl_t c, input logic w, input logic r, input logic [17:0] d, input logic s);
      if (w && r && !c.load_sel)
         r = 1'b0;
      @(posedge clock_i);
      ctl_o <= c;
      write_clock_o <= w;
      read_clock_o <= r;
      data_o <= d;
      serial_o <= s;
      @(posedge clock_i);
      ctl_o <= 4'b1111;
      write_clock_o <= 1'b0;
      read_clock_o <= 1'b0;
      data_o <= ~d;
      serial_o <= ~s;
   endtask
endmodule

// file: bench/ffo_offset_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module ffo_offset_checker
   import ffo_pkg::*;
#(
   parameter int DATA_W = 18,
   parameter int OFS_W  = 13
)
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic              master_reset_n_i,
   input  wire logic              partial_reset_n_i,
   input  wire ffo_ctl_t          ctl_i,
   input  wire logic              write_clock_i,
   input  wire logic              read_clock_i,
   input  wire logic [DATA_W-1:0] data_out_o,
   input  wire logic              almost_empty_flag_o,
   input  wire logic              almost_full_flag_o,
   input  wire logic              input_ready_flag_o,
   input  wire logic              almost_empty_valid_o,
   input  wire logic              almost_full_valid_o,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic              avs_waitrequest_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   a_wait_one: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("waitrequest not one cycle");
   a_idle_nowait: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
   a_mrs_clear: assert property (!master_reset_n_i |=> data_out_o == '0 && almost_empty_valid_o &&
      almost_full_valid_o && !almost_empty_flag_o && almost_full_flag_o && !input_ready_flag_o)
      else $error("master reset state wrong");
   a_prst_clear: assert property (!partial_reset_n_i |=> data_out_o == '0 && !input_ready_flag_o)
      else $error("partial reset state wrong");
   a_full_valid: assert property ($rose(almost_full_valid_o) && $past(master_reset_n_i) && $past(rstn_i)
      |-> $past(write_clock_i))
      else $error("full flag valid without write edge");
   a_empty_valid: assert property ($rose(almost_empty_valid_o) && $past(master_reset_n_i) && $past(rstn_i)
      |-> $past(read_clock_i))
      else $error("empty flag valid without read edge");
   a_ofs_read: assert property (master_reset_n_i && partial_reset_n_i && read_clock_i && ctl_i == 4'b0101
      |=> data_out_o[DATA_W-1:OFS_W] == '0)
      else $error("offset read upper bits set");
   a_dout_hold: assert property (master_reset_n_i && partial_reset_n_i && !read_clock_i |=> $stable(data_out_o))
      else $error("output word changed without read");
endmodule
bind ffo_offset ffo_offset_checker #(.DATA_W(DATA_W), .OFS_W(OFS_W)) u_ffo_offset_checker (.*);

// file: bench/ffo_offset_tb.sv
`timescale 1ns/1ps
module ffo_offset_tb;
   import ffo_pkg::*;
   logic        clock_i, rstn_i, master_reset_n_i, partial_reset_n_i, fall_through_mode_i;
   ffo_ctl_t    ctl_i;
   logic        write_clock_i, read_clock_i, serial_offset_in_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic        almost_empty_flag_o, almost_full_flag_o, input_ready_flag_o, almost_empty_valid_o, almost_full_valid_o;
   logic [17:0] data_in_i, data_out_o;
   logic [3:0]  avs_address_i, avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [25:0] chain;
   int          fail_count, n_checks;
   localparam ffo_ctl_t PW = 4'b0011, PR = 4'b0101, SS = 4'b0110, MW = 4'b1011, MR = 4'b1101, NP = 4'b0111;
   ffo_offset #(.DEPTH(64)) u_ffo_offset (.*);
   ffo_ctrl_model u_ffo_ctrl_model (.clock_i(clock_i), .ctl_o(ctl_i), .write_clock_o(write_clock_i),
      .read_clock_o(read_clock_i), .data_o(data_in_i), .serial_o(serial_offset_in_i));
   initial
   begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0)
         @(posedge clock_i);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic op(input ffo_ctl_t c, input logic w, input logic r, input logic [17:0] d, input logic s);
      u_ffo_ctrl_model.drive(c, w, r, d, s);
      @(negedge clock_i);
   endtask
   task automatic mres(input logic ld, input logic ft);
      u_ffo_ctrl_model.hold({ld, 3'b111});
      master_reset_n_i <= 1'b0;
      fall_through_mode_i <= ft;
      repeat (2) @(posedge clock_i);
      master_reset_n_i <= 1'b1;
      u_ffo_ctrl_model.hold(4'b1111);
   endtask
   function automatic logic [31:0] ofs(input logic [12:0] f, input logic [12:0] e);
      return {3'h0, f, 3'h0, e};
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_par;
      mres(1'b0, 1'b0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h7f, 13'h7f));
      avs(1'b0, 4'h0, 0); chk(rd, 32'h3);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h7f);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h7f);
      op(PW, 1, 0, 18'h5, 0);
      avs(1'b0, 4'h0, 0); chk(rd, 32'h0);
      op(MW, 1, 0, 18'h2abcd, 0);
      op(PW, 1, 0, 18'h9, 0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h9, 13'h5));
      repeat (2) op(NP, 1, 0, 0, 0);
      avs(1'b0, 4'h0, 0); chk(rd, 32'h1);
      repeat (2) op(NP, 0, 1, 0, 0);
      avs(1'b0, 4'h0, 0); chk(rd, 32'h3);
      op(PW, 1, 0, 18'h3ff11, 0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h9, 13'h1f11));
      $display("t_par done");
   endtask
   task automatic t_rd;
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h1f11);
      op(MR, 0, 1, 0, 0); chk(data_out_o, 18'h2abcd);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h9);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h1f11);
      $display("t_rd done");
   endtask
   task automatic t_prst;
      @(posedge clock_i);
      partial_reset_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      partial_reset_n_i <= 1'b1;
      @(negedge clock_i);
      chk(data_out_o, 18'h0);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h9);
      op(PW, 1, 0, 18'h42, 0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h42, 13'h1f11));
      $display("t_prst done");
   endtask
   task automatic t_ctrl;
      avs(1'b1, 4'h8, 32'h0);
      op(PW, 1, 0, 18'h77, 0);
      avs(1'b1, 4'h2, 32'h0);
      avs(1'b1, 4'h8, 32'h1);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h42, 13'h1f11));
      op(PW, 1, 0, 18'h55, 0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h42, 13'h55));
      $display("t_ctrl done");
   endtask
   task automatic t_ser;
      chain = {13'h1234, 13'h0321};
      mres(1'b1, 1'b0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h3ff, 13'h3ff));
      avs(1'b0, 4'h0, 0); chk(rd, 32'h7);
      op(PW, 1, 0, 18'h11, 0);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h3ff, 13'h3ff));
      for (int i = 0; i < 10; i++)
         op(SS, 1, 0, 0, chain[i]);
      avs(1'b0, 4'hc, 0); chk(rd, 32'd10);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h3ff, 13'h3ff));
      avs(1'b0, 4'h0, 0); chk(rd, 32'h4);
      op(MW, 1, 0, 18'h1, 1);
      op(NP, 1, 0, 0, 1);
      avs(1'b0, 4'hc, 0); chk(rd, 32'd10);
      for (int i = 10; i < 26; i++)
         op(SS, 1, 0, 0, chain[i]);
      avs(1'b0, 4'h4, 0); chk(rd, ofs(13'h1234, 13'h0321));
      repeat (2) op(NP, 1, 0, 0, 0);
      repeat (2) op(NP, 0, 1, 0, 0);
      avs(1'b0, 4'h0, 0); chk(rd, 32'h7);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h0321);
      $display("t_ser done");
   endtask
   task automatic t_ft;
      mres(1'b0, 1'b1);
      avs(1'b0, 4'h0, 0); chk(rd, 32'hb);
      op(PR, 0, 1, 0, 0); chk(data_out_o, 18'h7f);
      op(PW, 1, 0, 18'h3, 0);
      op(PW, 1, 0, 18'h5, 0);
      repeat (4) op(MW, 1, 0, 18'h1, 0);
      op(NP, 0, 1, 0, 0); chk(data_out_o, 18'h1);
      chk(almost_empty_flag_o, 1'b0);
      chk(almost_full_flag_o, 1'b1);
      op(MW, 1, 0, 18'h2, 0);
      chk(almost_empty_flag_o, 1'b1);
      repeat (59) op(MW, 1, 0, 18'h3, 0);
      chk(input_ready_flag_o, 1'b0);
      chk(almost_full_flag_o, 1'b0);
      op(MW, 1, 0, 18'h4, 0);
      chk(input_ready_flag_o, 1'b1);
      $display("t_ft done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #100us;
      fail_count++;
      end_of_test();
   end
   initial
   begin
      fail_count = 0;
      n_checks = 0;
      rstn_i = 1'b0;
      master_reset_n_i = 1'b1;
      partial_reset_n_i = 1'b1;
      fall_through_mode_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hf;
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      t_par();
      t_rd();
      t_prst();
      t_ctrl();
      t_ser();
      t_ft();
      end_of_test();
   end
endmodule
